// File: core/wwds_supervisor.sv
// Reset supervisor with standard and windowed watchdog
`timescale 1ns/100ps
module wwds_supervisor
  import wwds_pkg::*;
#(
  parameter wwds_kind_t WD_KIND = WWDS_WD_STANDARD,
  parameter int unsigned MR_QUAL_CYC = WWDS_MR_QUAL_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic supply_low,
  input wire logic aux_low,
  input wire logic manual_reset_in_n,
  input wire logic watchdog_strobe_in,
  input wire logic watchdog_range_select,
  input wire logic watchdog_period_cfg,
  input wire logic window_ratio_sel_a,
  input wire logic window_ratio_sel_b,
  input wire logic [WWDS_CNT_W-1:0] reset_hold_cfg,
  input wire logic [WWDS_CNT_W-1:0] watchdog_period_cycles,
  input wire logic [WWDS_CNT_W-1:0] slow_window_limit,
  output logic reset_out_n,
  output logic wd_fault_q
);

  wwds_cause_t cause;
  logic manual_active;
  logic [WWDS_CNT_W-1:0] hold_cnt_q;
  logic reset_q;
  logic strobe_q;
  logic range_q;
  logic [1:0] ratio_q;
  logic [WWDS_CNT_W+WWDS_EXT_SHIFT-1:0] wd_cnt_q;
  logic [WWDS_CNT_W-1:0] win_cnt_q;
  logic fall;
  logic [1:0] ratio_now;
  logic win_off;
  logic [WWDS_CNT_W-1:0] fast_window_limit;
  logic [WWDS_CNT_W+WWDS_EXT_SHIFT-1:0] watchdog_timeout;
  logic std_fault;
  logic win_fault;

  // Fast limit as slow limit shifted by the strapped ratio
  function automatic logic [WWDS_CNT_W-1:0] fast_of(input logic [1:0] code,
                                                    input logic [WWDS_CNT_W-1:0] slow);
    unique case (code)
      WWDS_RATIO_8: fast_of = slow >> WWDS_SHIFT_8;
      WWDS_RATIO_16: fast_of = slow >> WWDS_SHIFT_16;
      WWDS_RATIO_64: fast_of = slow >> WWDS_SHIFT_64;
      default: fast_of = '0;
    endcase
  endfunction

  wwds_mr_filter #(.QUAL_CYC(MR_QUAL_CYC)) u_mr (
    .core_clk(core_clk),
    .rst(rst),
    .manual_reset_in_n(manual_reset_in_n),
    .manual_active_q(manual_active)
  );

  // Combine every cause of reset
  always_comb begin
    cause.supply_low = supply_low;
    cause.aux_low = aux_low;
    cause.manual = manual_active;
    cause.wd_fault = std_fault | win_fault;
  end

  assign fall = strobe_q & ~watchdog_strobe_in;
  assign ratio_now = {window_ratio_sel_a, window_ratio_sel_b};
  assign win_off = (ratio_now == WWDS_RATIO_OFF);
  assign fast_window_limit = fast_of(ratio_now, slow_window_limit);
  // Extended range is an exact times-128 of the normal count
  assign watchdog_timeout = watchdog_range_select ?
    {watchdog_period_cycles, WWDS_EXT_SHIFT'(0)} :
    {{WWDS_EXT_SHIFT{1'b0}}, watchdog_period_cycles};

  // Standard watchdog fault: no strobe within the timeout
  assign std_fault = (WD_KIND == WWDS_WD_STANDARD) && !reset_q && watchdog_period_cfg &&
    (wd_cnt_q + 1'b1 >= watchdog_timeout);

  // Window fault: early edge before the fast limit, or no edge by the slow limit
  assign win_fault = (WD_KIND == WWDS_WD_WINDOW) && !reset_q && !win_off &&
    (ratio_now == ratio_q) &&
    ((fall && win_cnt_q < fast_window_limit) ||
     (win_cnt_q + 1'b1 >= slow_window_limit));

  // Reset pulse stretcher; a watchdog fault uses the same hold count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reset_q <= 1'b1;
      hold_cnt_q <= '0;
    end else if (cause.supply_low || cause.aux_low || cause.manual || cause.wd_fault) begin
      reset_q <= 1'b1;
      hold_cnt_q <= '0;
    end else if (reset_q) begin
      // Hold runs from release of the last cause
      if (hold_cnt_q + 1'b1 >= reset_hold_cfg) begin
        reset_q <= 1'b0;
      end
      hold_cnt_q <= hold_cnt_q + 1'b1;
    end
  end

  // Output straight from flip-flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reset_out_n <= 1'b0;
      wd_fault_q <= 1'b0;
    end else begin
      reset_out_n <= ~(reset_q | cause.supply_low | cause.aux_low | cause.manual |
                       cause.wd_fault);
      wd_fault_q <= cause.wd_fault;
    end
  end

  // Input history for edge and change detection
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strobe_q <= 1'b1;
      range_q <= 1'b0;
      ratio_q <= 2'h0;
    end else begin
      strobe_q <= watchdog_strobe_in;
      range_q <= watchdog_range_select;
      ratio_q <= ratio_now;
    end
  end

  // Standard watchdog counter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wd_cnt_q <= '0;
    end else if (reset_q || fall || (range_q != watchdog_range_select) || std_fault) begin
      wd_cnt_q <= '0;
    end else begin
      wd_cnt_q <= wd_cnt_q + 1'b1;
    end
  end

  // Window counter; strobes are not looked at while reset stands
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      win_cnt_q <= '0;
    end else if (reset_q) begin
      win_cnt_q <= '0;
    end else if (ratio_now != ratio_q) begin
      win_cnt_q <= '0;
    end else if (fall || win_fault) begin
      win_cnt_q <= '0;
    end else begin
      win_cnt_q <= win_cnt_q + 1'b1;
    end
  end

  // Checks on the behaviour
  supply_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    (supply_low || aux_low) |=> !reset_out_n)
    else $error("undervoltage did not assert reset");

  manual_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(manual_active) && reset_hold_cfg > 2 |=> !reset_out_n [*2])
    else $error("reset released early after manual reset");

  std_timeout_a: assert property (@(posedge core_clk) disable iff (rst)
    std_fault |=> !reset_out_n && wd_cnt_q == 0)
    else $error("standard timeout gave no reset");

  std_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    (fall || $changed(watchdog_range_select)) && !$past(reset_q) |=> wd_cnt_q == 0)
    else $error("standard counter not cleared");

  std_held_a: assert property (@(posedge core_clk) disable iff (rst)
    reset_q |=> wd_cnt_q == 0)
    else $error("standard counter ran during reset");

  std_disable_a: assert property (@(posedge core_clk) disable iff (rst)
    !watchdog_period_cfg |-> !std_fault)
    else $error("disabled watchdog faulted");

  ext_range_a: assert property (@(posedge core_clk) disable iff (rst)
    watchdog_range_select |-> watchdog_timeout == (watchdog_period_cycles * 128))
    else $error("extended timeout not times 128");

  win_early_a: assert property (@(posedge core_clk) disable iff (rst)
    WD_KIND == WWDS_WD_WINDOW && !reset_q && !win_off && ratio_now == ratio_q && fall &&
    win_cnt_q < fast_window_limit |=> !reset_out_n)
    else $error("early strobe missed");

  win_ok_a: assert property (@(posedge core_clk) disable iff (rst)
    fall && win_cnt_q >= fast_window_limit && win_cnt_q + 1 < slow_window_limit |-> !win_fault)
    else $error("in-window strobe faulted");

  win_strap_a: assert property (@(posedge core_clk) disable iff (rst)
    ratio_now != ratio_q |=> win_cnt_q == 0)
    else $error("strap change did not clear window counter");

  win_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    reset_q |=> win_cnt_q == 0)
    else $error("window counter ran during reset");

  manual_c: cover property (@(posedge core_clk) disable iff (rst) $rose(manual_active));
  std_fault_c: cover property (@(posedge core_clk) disable iff (rst) std_fault);
  win_fault_c: cover property (@(posedge core_clk) disable iff (rst) win_fault);
  release_c: cover property (@(posedge core_clk) disable iff (rst) $rose(reset_out_n));

endmodule

// File: core/wwds_pkg.sv
// Package of constants and carrier types for the windowed watchdog supervisor
package wwds_pkg;

  localparam int unsigned WWDS_CLK_MHZ = 100;
  // Manual reset qualification, least time in ns
  localparam int unsigned WWDS_MR_QUAL_NS = 1000;
  localparam int unsigned WWDS_MR_QUAL_CYC = (WWDS_MR_QUAL_NS * WWDS_CLK_MHZ + 999) / 1000;
  // Shortest strobe pulse the standard watchdog must catch, in ns
  localparam int unsigned WWDS_STROBE_MIN_NS = 300;
  localparam int unsigned WWDS_STROBE_MIN_CYC = (WWDS_STROBE_MIN_NS * WWDS_CLK_MHZ) / 1000;
  // Extended range multiplier as a shift
  localparam int unsigned WWDS_EXT_SHIFT = 7;
  localparam int unsigned WWDS_CNT_W = 32;
  // Default timing counts in cycles
  localparam logic [31:0] WWDS_HOLD_DEF = 32'h0000_c350;
  localparam logic [31:0] WWDS_WD_DEF = 32'h000f_4240;
  localparam logic [31:0] WWDS_SLOW_DEF = 32'h000f_4240;
  // Ratio codes as {sel_a, sel_b}
  localparam logic [1:0] WWDS_RATIO_8 = 2'h0;
  localparam logic [1:0] WWDS_RATIO_16 = 2'h1;
  localparam logic [1:0] WWDS_RATIO_OFF = 2'h2;
  localparam logic [1:0] WWDS_RATIO_64 = 2'h3;
  localparam int unsigned WWDS_SHIFT_8 = 3;
  localparam int unsigned WWDS_SHIFT_16 = 4;
  localparam int unsigned WWDS_SHIFT_64 = 6;

  // Reset causes seen by the supervisor
  typedef struct packed {
    logic supply_low;
    logic aux_low;
    logic manual;
    logic wd_fault;
  } wwds_cause_t;

  typedef enum logic [1:0] {WWDS_WD_NONE, WWDS_WD_STANDARD, WWDS_WD_WINDOW} wwds_kind_t;

endpackage

// File: core/wwds_mr_filter.sv
// Glitch filter for the manual reset input
`timescale 1ns/100ps
module wwds_mr_filter
  import wwds_pkg::*;
#(
  parameter int unsigned QUAL_CYC = WWDS_MR_QUAL_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic manual_reset_in_n,
  output logic manual_active_q
);

  logic [15:0] low_cnt_q;

  // Count continuous low time; any high sample restarts it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_cnt_q <= 16'h0000;
      manual_active_q <= 1'b0;
    end else if (manual_reset_in_n) begin
      low_cnt_q <= 16'h0000;
      manual_active_q <= 1'b0;
    end else begin
      if (low_cnt_q < 16'(QUAL_CYC)) begin
        low_cnt_q <= low_cnt_q + 16'h0001;
      end
      manual_active_q <= (low_cnt_q >= 16'(QUAL_CYC - 1));
    end
  end

  qual_time_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(manual_active_q) |-> $past(!manual_reset_in_n, 1) && $past(!manual_reset_in_n, 2))
    else $error("manual reset qualified without a held low");

endmodule

// File: testbench/wwds_cpu_model.sv
// Model of the supervised processor driving the watchdog strobe
`timescale 1ns/100ps
module wwds_cpu_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic [31:0] gap,
  output logic strobe
);
  int cnt;
  // One falling edge every gap cycles after reset; long gaps use a 3-cycle low pulse,
  // a tenth of the 30-cycle shortest strobe that the standard watchdog must catch
  always_ff @(posedge core_clk) begin
    if (!reset_n || !enable) begin
      cnt <= 0;
      strobe <= 1'b1;
    end else begin
      cnt <= (cnt + 1 == gap) ? 0 : cnt + 1;
      if (cnt + 1 == gap) begin
        strobe <= 1'b0;
      end else if (cnt == (gap > 60 ? 2 : gap / 2)) begin
        strobe <= 1'b1;
      end
    end
  end
endmodule

// File: testbench/tb_windowed_watchdog_supervisor.sv
// Testbench for the windowed watchdog supervisor
`timescale 1ns/100ps
module tb_windowed_watchdog_supervisor;
  import wwds_pkg::*;
  localparam int HOLD = 5;
  localparam int PER = 100;
  localparam int SLOW = 1024;
  logic core_clk, rst, supply_low, aux_low, mr_n, wrange, wcfg, sa, sb, use_win, en;
  logic s_rst_n, w_rst_n, s_flt, w_flt, strobe, f, ex;
  logic [31:0] gap;
  int errors = 0, tests_run = 0, cyc = 0, n, g, sh;
  // Standard and windowed instances share every input
  wwds_supervisor #(.WD_KIND(WWDS_WD_STANDARD), .MR_QUAL_CYC(100)) dut (.core_clk, .rst,
    .supply_low, .aux_low, .manual_reset_in_n(mr_n), .watchdog_strobe_in(strobe),
    .watchdog_range_select(wrange), .watchdog_period_cfg(wcfg), .window_ratio_sel_a(sa),
    .window_ratio_sel_b(sb), .reset_hold_cfg(32'(HOLD)), .watchdog_period_cycles(32'(PER)),
    .slow_window_limit(32'(SLOW)), .reset_out_n(s_rst_n), .wd_fault_q(s_flt));
  wwds_supervisor #(.WD_KIND(WWDS_WD_WINDOW), .MR_QUAL_CYC(100)) dut_win (.core_clk, .rst,
    .supply_low, .aux_low, .manual_reset_in_n(mr_n), .watchdog_strobe_in(strobe),
    .watchdog_range_select(wrange), .watchdog_period_cfg(wcfg), .window_ratio_sel_a(sa),
    .window_ratio_sel_b(sb), .reset_hold_cfg(32'(HOLD)), .watchdog_period_cycles(32'(PER)),
    .slow_window_limit(32'(SLOW)), .reset_out_n(w_rst_n), .wd_fault_q(w_flt));
  wwds_cpu_model cpu (.core_clk, .reset_n(use_win ? w_rst_n : s_rst_n), .enable(en), .gap,
    .strobe);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Cycle ceiling cuts a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Cycle counts pass within a tolerance, since edge detection adds a cycle or two
  task automatic chk(string nm, int e, int s, int tol);
    tests_run++;
    if (s < e - tol || s > e + tol) begin
      errors++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, s);
    end
    $display("test %s done", nm);
  endtask
  task automatic chk_l(string nm, logic e, logic s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, s);
    end
    $display("test %s done", nm);
  endtask
  function automatic logic pick(int k);
    return k == 0 ? s_flt : k == 1 ? w_flt : k == 2 ? ~s_rst_n : ~w_rst_n;
  endfunction
  // Sampled at the falling edge so that design updates have landed
  task automatic wait_for(int k, logic v, output int c);
    c = 0;
    while (pick(k) !== v && c < 20000) begin
      @(negedge core_clk);
      c++;
    end
  endtask
  task automatic watch(int k, int c, output logic hit);
    hit = 1'b0;
    repeat (c) begin
      @(negedge core_clk);
      if (pick(k) === 1'b1) hit = 1'b1;
    end
  endtask
  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    wait_for(2, 1'b0, n);
    chk("release", HOLD + 1, n, 1);
    wait_for(3, 1'b0, n);
  endtask
  initial begin
    {rst, supply_low, aux_low, wrange, sa, sb, use_win, en} = '0;
    rst = 1'b1;
    mr_n = 1'b1;
    wcfg = 1'b1;
    gap = '0;
    g = $urandom(32'hfbc4);
    do_reset();
    // Standard timeout in both ranges; reset pulse the same length in each
    for (int r = 0; r < 2; r++) begin
      @(posedge core_clk);
      wrange <= r[0];
      wait_for(2, 1'b0, n);
      wait_for(0, 1'b1, n);
      chk("timeout", r ? PER * 128 : PER, n, 3);
      wait_for(2, 1'b0, n);
      chk("pulse", HOLD + 1, n, 2);
    end
    // A short blip on range select restarts the count
    @(posedge core_clk);
    wrange <= 1'b0;
    repeat (PER / 2) @(posedge core_clk);
    wrange <= 1'b1;
    @(posedge core_clk);
    wrange <= 1'b0;
    wait_for(0, 1'b1, n);
    chk("range clear", PER, n, 3);
    wait_for(2, 1'b0, n);
    @(posedge core_clk);
    gap <= 32'd70;
    en <= 1'b1;
    watch(0, 5 * PER, f);
    chk_l("strobed", 1'b0, f);
    @(posedge core_clk);
    en <= 1'b0;
    wcfg <= 1'b0;
    watch(0, 3 * PER, f);
    chk_l("disabled", 1'b0, f);
    // Each supply comparator alone holds reset
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      {supply_low, aux_low} <= i ? 2'b01 : 2'b10;
      repeat (2) @(negedge core_clk);
      chk_l("supply", 1'b0, s_rst_n);
      @(posedge core_clk);
      {supply_low, aux_low} <= 2'b00;
      wait_for(2, 1'b0, n);
      chk("supply hold", HOLD + 1, n, 2);
    end
    // Manual press shorter then longer than qualification
    for (int w = 50; w <= 110; w += 60) begin
      @(posedge core_clk);
      mr_n <= 1'b0;
      repeat (w) @(negedge core_clk);
      chk_l("manual", w > 100, ~s_rst_n);
      @(posedge core_clk);
      mr_n <= 1'b1;
      wait_for(2, 1'b0, n);
      chk("manual hold", w > 100 ? HOLD + 1 : 0, n, 3);
    end
    // Window: each strap code with an early and an in-window strobe
    use_win <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      sh = c[2:1] == 0 ? 3 : c[2:1] == 1 ? 4 : 6;
      g = (SLOW >> sh) + 8 + int'($urandom % (SLOW - (SLOW >> sh) - 16));
      if (c[0]) g = (SLOW >> sh) - 4;
      ex = c[2:1] != WWDS_RATIO_OFF && g < (SLOW >> sh);
      @(posedge core_clk);
      {sa, sb} <= c[2:1];
      gap <= 32'(g);
      en <= 1'b1;
      do_reset();
      watch(1, 3 * g, f);
      chk_l("window", ex, f);
    end
    // Late strobe faults at the slow limit; a strap blip restarts the count
    for (int t = 0; t < 2; t++) begin
      @(posedge core_clk);
      {sa, sb} <= 2'b00;
      en <= 1'b0;
      do_reset();
      repeat (SLOW / 2) @(posedge core_clk);
      sb <= t[0];
      @(posedge core_clk);
      sb <= 1'b0;
      wait_for(1, 1'b1, n);
      chk("late", t ? SLOW : SLOW / 2, n, 4);
    end
    stop_test();
  end
endmodule
